// >>> core/dcir_pkg.sv
// Package with constants for the dual core interrupt router
package dcir_pkg;

  // Source and line counts
  localparam int unsigned NUM_SRC       = 147;
  localparam int unsigned NUM_SEC_LINES = 32;
  localparam int unsigned NUM_WAKE      = 41;

  // Field widths
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned SEL_W         = 8;
  localparam int unsigned MAIN_PRIO_W   = 3;
  localparam int unsigned SEC_PRIO_W    = 2;

  // Register word offsets on the plain register port
  localparam logic [9:0] OFS_MAIN_PRIO  = 10'h000;
  localparam logic [9:0] OFS_MAIN_LAST  = 10'h092;
  localparam logic [9:0] OFS_SEC_MAP    = 10'h100;
  localparam logic [9:0] OFS_SEC_LAST   = 10'h11f;
  localparam logic [9:0] OFS_MAIN_NMI   = 10'h120;
  localparam logic [9:0] OFS_SEC_NMI    = 10'h121;
  localparam logic [9:0] OFS_WAKE_EN    = 10'h130;
  localparam logic [9:0] OFS_WAKE_LAST  = 10'h131;
  localparam logic [9:0] OFS_STATUS     = 10'h140;
  localparam logic [9:0] OFS_STAT_LAST  = 10'h144;

  // Field positions inside a secondary map word
  localparam int unsigned SEC_SEL_LSB   = 0;
  localparam int unsigned SEC_PRIO_LSB  = 8;

  // Reset values
  localparam logic [7:0]  SEL_NONE      = 8'hff;
  localparam logic [2:0]  MAIN_PRIO_RST = 3'h0;
  localparam logic [1:0]  SEC_PRIO_RST  = 2'h0;
  localparam logic [40:0] WAKE_EN_RST   = 41'h000_0000_0000;

  // Whole state of the router
  typedef struct packed {
    logic [146:0]      main_irq;
    logic [31:0]       sec_irq;
    logic              main_nmi;
    logic              sec_nmi;
    logic              wake_req;
    logic [31:0]       rdata;
    logic [146:0][2:0] main_prio;
    logic [31:0][7:0]  sec_sel;
    logic [31:0][1:0]  sec_prio;
    logic [7:0]        main_nmi_sel;
    logic [7:0]        sec_nmi_sel;
    logic [40:0]       wake_en;
  } dcir_state_t;

endpackage : dcir_pkg

// >>> core/dcir_router.sv
// Interrupt router feeding a main core and a secondary core
// How it works
// - 147 sources map one-to-one onto main lines
// - 32 secondary lines, each picks one source
// - Priorities: eight levels main, four secondary
// - One selected source per core drives NMI
// - Only sources 0..40 may request wakeup
`timescale 1ns/1ps

module dcir_router
  import dcir_pkg::*;
(
  input  wire logic              sys_clk,            // System clock, 100 MHz
  input  wire logic              reset_n,            // Synchronous reset, active low
  input  wire logic [146:0]      src_irq,            // Peripheral interrupt sources
  input  wire logic              deep_sleep,         // Device is in deep sleep
  input  wire logic [9:0]        reg_addr,           // Register word address
  input  wire logic [31:0]       reg_wdata,          // Register write data
  input  wire logic              reg_wr,             // Write strobe
  input  wire logic              reg_rd,             // Read strobe
  output logic      [31:0]       reg_rdata,          // Read data, cycle after strobe
  output logic      [146:0]      main_core_irq,      // Main core request lines
  output logic      [440:0]      main_core_prio,     // Main core priority, 3 bits each
  output logic                   main_core_nmi,      // Main core non-maskable input
  output logic      [31:0]       secondary_core_irq, // Secondary core request lines
  output logic      [63:0]       secondary_core_prio,// Secondary priority, 2 bits each
  output logic                   secondary_core_nmi, // Secondary non-maskable input
  output logic                   wake_req            // Wakeup to wake_interrupt_unit
);

  dcir_state_t state_reg;
  dcir_state_t state_next;

  // Pick one source by index, low when the index is unassigned
  function automatic logic pick_src(input logic [146:0] src, input logic [7:0] sel);
    logic hit;
    hit = 1'b0;
    if (sel < 8'(NUM_SRC))
    begin
      hit = src[sel];
    end
    return hit;
  endfunction : pick_src

  // Word views for the wide read paths
  logic [159:0] stat_words;
  logic [63:0]  wake_words;
  logic [4:0]   sec_idx;
  logic [2:0]   stat_idx;

  assign stat_words = {13'h0000, state_reg.main_irq};
  assign wake_words = {23'h00_0000, state_reg.wake_en};
  assign sec_idx    = reg_addr[4:0];
  assign stat_idx   = 3'(reg_addr - OFS_STATUS);

  // Next-state logic: routing, register writes and read data
  always_comb
  begin
    state_next = state_reg;

    // Direct one-to-one copy for the main core
    state_next.main_irq = src_irq;

    // Per-line selection for the secondary core
    for (int i = 0; i < NUM_SEC_LINES; i++)
    begin
      state_next.sec_irq[i] = pick_src(src_irq, state_reg.sec_sel[i]);
    end

    // Single selected source per core on the NMI
    state_next.main_nmi = pick_src(src_irq, state_reg.main_nmi_sel);
    state_next.sec_nmi  = pick_src(src_irq, state_reg.sec_nmi_sel);

    // Wakeup only from capable, enabled sources in deep sleep
    state_next.wake_req = deep_sleep &
                          (|(src_irq[NUM_WAKE-1:0] & state_reg.wake_en));

    // Register writes
    if (reg_wr)
    begin
      if (reg_addr <= OFS_MAIN_LAST)
      begin
        state_next.main_prio[reg_addr[7:0]] = reg_wdata[2:0];
      end
      else if (reg_addr >= OFS_SEC_MAP && reg_addr <= OFS_SEC_LAST)
      begin
        state_next.sec_sel[sec_idx]  = reg_wdata[SEC_SEL_LSB +: SEL_W];
        state_next.sec_prio[sec_idx] = reg_wdata[SEC_PRIO_LSB +: SEC_PRIO_W];
      end
      else if (reg_addr == OFS_MAIN_NMI)
      begin
        state_next.main_nmi_sel = reg_wdata[7:0];
      end
      else if (reg_addr == OFS_SEC_NMI)
      begin
        state_next.sec_nmi_sel = reg_wdata[7:0];
      end
      else if (reg_addr == OFS_WAKE_EN)
      begin
        state_next.wake_en[31:0] = reg_wdata;
      end
      else if (reg_addr == OFS_WAKE_LAST)
      begin
        state_next.wake_en[40:32] = reg_wdata[8:0];
      end
    end

    // Read data, valid only in the cycle after the strobe
    state_next.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      if (reg_addr <= OFS_MAIN_LAST)
      begin
        state_next.rdata = {29'h0000_0000, state_reg.main_prio[reg_addr[7:0]]};
      end
      else if (reg_addr >= OFS_SEC_MAP && reg_addr <= OFS_SEC_LAST)
      begin
        state_next.rdata = {22'h00_0000, state_reg.sec_prio[sec_idx],
                            state_reg.sec_sel[sec_idx]};
      end
      else if (reg_addr == OFS_MAIN_NMI)
      begin
        state_next.rdata = {24'h00_0000, state_reg.main_nmi_sel};
      end
      else if (reg_addr == OFS_SEC_NMI)
      begin
        state_next.rdata = {24'h00_0000, state_reg.sec_nmi_sel};
      end
      else if (reg_addr == OFS_WAKE_EN || reg_addr == OFS_WAKE_LAST)
      begin
        state_next.rdata = wake_words[reg_addr[0]*32 +: 32];
      end
      else if (reg_addr >= OFS_STATUS && reg_addr <= OFS_STAT_LAST)
      begin
        state_next.rdata = stat_words[stat_idx*32 +: 32];
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_reg.main_irq     <= '0;
      state_reg.sec_irq      <= '0;
      state_reg.main_nmi     <= 1'b0;
      state_reg.sec_nmi      <= 1'b0;
      state_reg.wake_req     <= 1'b0;
      state_reg.rdata        <= '0;
      state_reg.main_prio    <= {NUM_SRC{MAIN_PRIO_RST}};
      state_reg.sec_sel      <= {NUM_SEC_LINES{SEL_NONE}};
      state_reg.sec_prio     <= {NUM_SEC_LINES{SEC_PRIO_RST}};
      state_reg.main_nmi_sel <= SEL_NONE;
      state_reg.sec_nmi_sel  <= SEL_NONE;
      state_reg.wake_en      <= WAKE_EN_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata           = state_reg.rdata;
  assign main_core_irq       = state_reg.main_irq;
  assign main_core_prio      = state_reg.main_prio;
  assign main_core_nmi       = state_reg.main_nmi;
  assign secondary_core_irq  = state_reg.sec_irq;
  assign secondary_core_prio = state_reg.sec_prio;
  assign secondary_core_nmi  = state_reg.sec_nmi;
  assign wake_req            = state_reg.wake_req;

endmodule : dcir_router

// >>> bench/dcir_core_model.sv
// Model of the two cores' request inputs
`timescale 1ns/1ps
module dcir_core_model (
  input  wire logic       sys_clk,            // Clock
  input  wire logic       reset_n,            // Sync reset
  input  wire logic       main_core_nmi,      // Main NMI
  input  wire logic       secondary_core_nmi, // Second NMI
  input  wire logic       wake_req,           // Wakeup
  output logic      [2:0] core_seen           // Sticky taken flags
);
  // Latch each request as a core would
  always_ff @(posedge sys_clk)
    core_seen <= !reset_n ? 3'h0
               : core_seen | {wake_req, secondary_core_nmi, main_core_nmi};
endmodule : dcir_core_model

// >>> bench/dcir_router_chk.sv
// Assertions on the router ports
`timescale 1ns/1ps
module dcir_router_chk
  import dcir_pkg::*;
(
  input wire logic         sys_clk,            // Clock
  input wire logic         reset_n,            // Sync reset
  input wire logic [146:0] src_irq,            // Sources
  input wire logic         deep_sleep,         // Sleep
  input wire logic         reg_wr,             // Write strobe
  input wire logic [146:0] main_core_irq,      // Main lines
  input wire logic [440:0] main_core_prio,     // Main prio
  input wire logic         main_core_nmi,      // Main NMI
  input wire logic [31:0]  secondary_core_irq, // Second lines
  input wire logic         secondary_core_nmi, // Second NMI
  input wire logic         wake_req            // Wakeup
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Request paths follow their sources
  a_main_map: assert property ($past(reset_n) |-> main_core_irq == $past(src_irq))
    else $error("main line mismatch");
  a_sec_quiet: assert property ($past(src_irq) == '0 |-> secondary_core_irq == '0)
    else $error("secondary line without source");
  a_prio_hold: assert property (!$past(reg_wr) && !$past(reg_wr, 2) && $past(reset_n)
    && $past(reset_n, 2)
    |-> $stable(main_core_prio))
    else $error("priority moved without write");
  a_nmi_quiet: assert property ($past(src_irq) == '0 |-> !main_core_nmi && !secondary_core_nmi)
    else $error("nmi without source");
  a_wake_sleep: assert property (wake_req |-> $past(deep_sleep))
    else $error("wake outside deep sleep");
  a_wake_src: assert property (wake_req |-> $past(src_irq[40:0]) != '0)
    else $error("wake from incapable source");
endmodule : dcir_router_chk

bind dcir_router dcir_router_chk chk_u (.sys_clk, .reset_n, .src_irq, .deep_sleep, .reg_wr,
  .main_core_irq, .main_core_prio, .main_core_nmi, .secondary_core_irq,
  .secondary_core_nmi, .wake_req);

// >>> bench/tb_dcir_router.sv
// Testbench for the interrupt router
`timescale 1ns/1ps
module tb_dcir_router;
  import dcir_pkg::*;
  logic         sys_clk = 0, reset_n = 0, deep_sleep = 0, reg_wr = 0, reg_rd = 0;
  logic [146:0] src_irq = '0, main_core_irq;
  logic [9:0]   reg_addr = '0;
  logic [31:0]  reg_wdata = '0, reg_rdata, secondary_core_irq;
  logic [440:0] main_core_prio;
  logic [63:0]  secondary_core_prio;
  logic         main_core_nmi, secondary_core_nmi, wake_req;
  logic [2:0]   core_seen;
  int           num_errors = 0, checks = 0, cyc = 0;
  // Rows: secondary line, source, priority
  int rows[4][3] = '{'{0, 5, 1}, '{31, 146, 3}, '{7, 0, 2}, '{15, 40, 0}};
  always #5 sys_clk = ~sys_clk;
  dcir_router dut_u (.sys_clk, .reset_n, .src_irq, .deep_sleep, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .main_core_irq, .main_core_prio, .main_core_nmi,
    .secondary_core_irq, .secondary_core_prio, .secondary_core_nmi, .wake_req);
  dcir_core_model core_u (.sys_clk, .reset_n, .main_core_nmi, .secondary_core_nmi,
    .wake_req, .core_seen);
  task stop_test;
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task src(input logic [146:0] v);
    src_irq <= v;
    @(posedge sys_clk);
    #1;
  endtask : src
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      num_errors++;
      stop_test;
    end
  end
  // Table cases, then awkward cases
  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(OFS_SEC_MAP, 32'hff);
    foreach (rows[i])
    begin
      wr(OFS_SEC_MAP + rows[i][0], {22'h0, rows[i][2][1:0], rows[i][1][7:0]});
      src(147'h1 << rows[i][1]);
      chk(secondary_core_irq[rows[i][0]], 1);
      chk(secondary_core_prio[2 * rows[i][0] +: 2], rows[i][2]);
      chk(|(main_core_irq ^ (147'h1 << rows[i][1])), 0);
    end
    wr(OFS_SEC_MAP + 3, 32'h93);
    src('1);
    chk({secondary_core_irq[3], secondary_core_irq[1], main_core_nmi}, 0);
    wr(OFS_MAIN_NMI, 32'h7);
    wr(OFS_SEC_NMI, 32'h92);
    src(147'h1 << 7);
    chk({main_core_nmi, secondary_core_nmi}, 2'b10);
    src(147'h1 << 146);
    chk({main_core_nmi, secondary_core_nmi}, 2'b01);
    rd(OFS_STAT_LAST, 32'h0004_0000);
    chk(core_seen[1:0], 2'b11);
    wr(OFS_MAIN_LAST, 32'h7);
    src('0);
    chk(main_core_prio[440:438], 3'h7);
    rd(OFS_MAIN_LAST, 32'h7);
    wr(OFS_WAKE_LAST, 32'h100);
    deep_sleep <= 1'b1;
    src(147'h1 << 41);
    chk(wake_req, 0);
    src(147'h1 << 40);
    chk(wake_req, 1);
    src(147'h1 << 40);
    chk(core_seen[2], 1);
    deep_sleep <= 1'b0;
    src(147'h1 << 40);
    chk(wake_req, 0);
    rd(10'h3ff, 32'h0);
    reset_n <= 1'b0;
    src('1);
    reset_n <= 1'b1;
    src('1);
    chk({secondary_core_irq, main_core_nmi, core_seen}, 0);
    rd(OFS_SEC_MAP + 31, 32'hff);
    stop_test;
  end
endmodule : tb_dcir_router
